// ==== fsef_defs.vh ====
`ifndef FSEF_DEFS_VH
`define FSEF_DEFS_VH
// register byte addresses (index times four)
`define FSEF_IDX_CONFIG 4
`define FSEF_IDX_ERR_CONFIG 5
`define FSEF_IDX_STATUS 6
`define FSEF_IDX_ERR_STATUS 7
`define FSEF_ADDR_CONFIG 12'h010
`define FSEF_ADDR_ERR_CONFIG 12'h014
`define FSEF_ADDR_STATUS 12'h018
`define FSEF_ADDR_ERR_STATUS 12'h01c
`define FSEF_ADDR_W 12
// status fields
`define FSEF_ST_DONE 7
`define FSEF_ST_ACCESS_ERROR_FLAG 5
`define FSEF_ST_PVIOL 4
`define FSEF_ST_BUSY 3
`define FSEF_ST_RSVD 2
// config fields
`define FSEF_CF_DONE_IE 7
`define FSEF_CF_IGN_SF 4
`define FSEF_CF_FORCE_DF 1
`define FSEF_CF_FORCE_SF 0
// error config / status fields
`define FSEF_EF_DF 1
`define FSEF_EF_SF 0
// reset values
`define FSEF_RST_CONFIG 8'h00
`define FSEF_RST_ERR_CONFIG 8'h00
`define FSEF_RST_DONE 1'b1
`endif

// ==== fsef_flash_status.v ====
// Our own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "fsef_defs.vh"

// Overview of operation
// - write one to done flag launches command
// - sequence break or illegal command sets access error
// - access error blocks command launch
// - access error cleared by writing one
// - protected program or erase sets violation flag
// - violation flag cleared by writing one
// - violation blocks launch and new sequences
// - busy reads one while command executes
// - status bit two always reads zero
// - result status shows command or reset errors
// - only three status bits accept writes
// - double fault or collision sets double flag
// - double flag cleared by writing one
// - single fault or collision sets single flag unless ignore bit set
// - single flag cleared by writing one
// - real fault raises at most one flag
// - collision raises double flag, single too unless ignored
// - done enable requests interrupt on done
// - double enable requests interrupt on double
// - single enable requests interrupt on single
// - forced double fault on every array read
module fsef_flash_status (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // command engine
    output wire cmd_launch,
    output wire seq_start_ok,
    input wire cmd_finish,
    input wire ctrl_busy,
    input wire [1:0] result_status,
    input wire seq_error,
    input wire illegal_cmd,
    input wire protect_hit,
    // array read fault detect
    input wire array_read,
    input wire ecc_single,
    input wire ecc_double,
    input wire read_collision,
    // interrupt requests
    output wire done_irq,
    output wire double_fault_irq,
    output wire single_fault_irq
);

    reg cmd_done_flag_ff;
    reg access_error_flag_ff;
    reg protect_violation_flag_ff;
    reg double_fault_flag_ff;
    reg single_fault_flag_ff;
    reg [7:0] flash_config_ff;
    reg [7:0] flash_error_config_ff;
    reg nxt_done;
    reg nxt_acc;
    reg nxt_pv;
    reg nxt_df;
    reg nxt_sf;
    reg [7:0] status_rd;
    reg [7:0] err_rd;

    wire wr_en = psel & penable & pwrite;
    wire lane0 = pstrb[0];
    wire wr_status = wr_en & lane0 & (paddr == `FSEF_ADDR_STATUS);
    wire wr_err = wr_en & lane0 & (paddr == `FSEF_ADDR_ERR_STATUS);
    wire wr_cfg = wr_en & lane0 & (paddr == `FSEF_ADDR_CONFIG);
    wire wr_ecfg = wr_en & lane0 & (paddr == `FSEF_ADDR_ERR_CONFIG);
    wire mapped = (paddr == `FSEF_ADDR_STATUS) | (paddr == `FSEF_ADDR_ERR_STATUS) |
        (paddr == `FSEF_ADDR_CONFIG) | (paddr == `FSEF_ADDR_ERR_CONFIG);

    // zero in the done bit does nothing; errors block the launch
    wire launch_req = wr_status & pwdata[`FSEF_ST_DONE];
    assign cmd_launch = launch_req & cmd_done_flag_ff & ~access_error_flag_ff
        & ~protect_violation_flag_ff;
    assign seq_start_ok = ~protect_violation_flag_ff;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // one-cycle classification: collision wins, else the fault kind
    wire sf_enabled = ~flash_config_ff[`FSEF_CF_IGN_SF];
    wire real_df = array_read & ecc_double & ~read_collision;
    wire real_sf = array_read & ecc_single & ~ecc_double & ~read_collision;
    wire forced_df = array_read & flash_config_ff[`FSEF_CF_FORCE_DF];
    wire forced_sf = array_read & flash_config_ff[`FSEF_CF_FORCE_SF];
    wire set_df = real_df | read_collision | forced_df;
    wire set_sf = sf_enabled & (real_sf | read_collision | forced_sf);

    always @* begin
        nxt_done = cmd_done_flag_ff;
        if (cmd_launch) begin
            nxt_done = 1'b0;
        end
        if (cmd_finish | seq_error | illegal_cmd | protect_hit) begin
            nxt_done = 1'b1;
        end
        // set wins over a same-cycle clear
        nxt_acc = access_error_flag_ff;
        if (wr_status & pwdata[`FSEF_ST_ACCESS_ERROR_FLAG]) begin
            nxt_acc = 1'b0;
        end
        if (seq_error | illegal_cmd | (launch_req & protect_violation_flag_ff)) begin
            nxt_acc = 1'b1;
        end
        nxt_pv = protect_violation_flag_ff;
        if (wr_status & pwdata[`FSEF_ST_PVIOL]) begin
            nxt_pv = 1'b0;
        end
        if (protect_hit) begin
            nxt_pv = 1'b1;
        end
        nxt_df = double_fault_flag_ff;
        if (wr_err & pwdata[`FSEF_EF_DF]) begin
            nxt_df = 1'b0;
        end
        if (set_df) begin
            nxt_df = 1'b1;
        end
        nxt_sf = single_fault_flag_ff;
        if (wr_err & pwdata[`FSEF_EF_SF]) begin
            nxt_sf = 1'b0;
        end
        if (set_sf) begin
            nxt_sf = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            cmd_done_flag_ff <= `FSEF_RST_DONE;
            access_error_flag_ff <= 1'b0;
            protect_violation_flag_ff <= 1'b0;
            double_fault_flag_ff <= 1'b0;
            single_fault_flag_ff <= 1'b0;
            flash_config_ff <= `FSEF_RST_CONFIG;
            flash_error_config_ff <= `FSEF_RST_ERR_CONFIG;
        end else begin
            cmd_done_flag_ff <= nxt_done;
            access_error_flag_ff <= nxt_acc;
            protect_violation_flag_ff <= nxt_pv;
            double_fault_flag_ff <= nxt_df;
            single_fault_flag_ff <= nxt_sf;
            if (wr_cfg) begin
                flash_config_ff <= pwdata[7:0] & 8'h93;
            end
            if (wr_ecfg) begin
                flash_error_config_ff <= pwdata[7:0] & 8'h03;
            end
        end
    end

    always @* begin
        status_rd = 8'h00;
        status_rd[`FSEF_ST_DONE] = cmd_done_flag_ff;
        status_rd[`FSEF_ST_ACCESS_ERROR_FLAG] = access_error_flag_ff;
        status_rd[`FSEF_ST_PVIOL] = protect_violation_flag_ff;
        status_rd[`FSEF_ST_BUSY] = ctrl_busy & ~cmd_done_flag_ff;
        status_rd[`FSEF_ST_RSVD] = 1'b0;
        status_rd[1:0] = result_status;
        err_rd = {6'h00, double_fault_flag_ff, single_fault_flag_ff};
    end

    // read data registered for the access phase
    always @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `FSEF_ADDR_STATUS: prdata <= {24'h000000, status_rd};
                `FSEF_ADDR_ERR_STATUS: prdata <= {24'h000000, err_rd};
                `FSEF_ADDR_CONFIG: prdata <= {24'h000000, flash_config_ff};
                `FSEF_ADDR_ERR_CONFIG: prdata <= {24'h000000, flash_error_config_ff};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign done_irq = flash_config_ff[`FSEF_CF_DONE_IE] & cmd_done_flag_ff;
    assign double_fault_irq = flash_error_config_ff[`FSEF_EF_DF] & double_fault_flag_ff;
    assign single_fault_irq = flash_error_config_ff[`FSEF_EF_SF] & single_fault_flag_ff;

endmodule
`default_nettype wire

// ==== fsef_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fsef_defs.vh"
module fsef_checker (
    // watched ports
    input wire clk, sys_rst, psel, penable, pwrite,
    input wire cmd_launch, seq_start_ok, protect_hit, illegal_cmd, done_irq,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, prdata,
    input wire [1:0] result_status
);
default clocking @(posedge clk); endclocking
default disable iff (sys_rst);
wire st_rd = psel & penable & ~pwrite & (paddr == `FSEF_ADDR_STATUS);
launch_cause_a: assert property (cmd_launch |-> psel && penable && pwrite
    && paddr == `FSEF_ADDR_STATUS && pwdata[7]) else $error("launch without cause");
viol_block_a: assert property (protect_hit |=> !seq_start_ok && !cmd_launch)
    else $error("violation not blocking");
viol_hold_a: assert property (!seq_start_ok |-> !cmd_launch)
    else $error("launch while violation");
acc_block_a: assert property (illegal_cmd |=> !cmd_launch)
    else $error("launch while access error");
rsvd_zero_a: assert property (st_rd |-> prdata[2] == 1'b0 && prdata[31:8] == 24'h0)
    else $error("reserved bits set");
busy_done_a: assert property (st_rd && prdata[3] |-> !prdata[7])
    else $error("busy with done set");
result_a: assert property (st_rd |-> prdata[1:0] == $past(result_status))
    else $error("result status wrong");
done_clear_a: assert property (cmd_launch |=> !done_irq)
    else $error("done not cleared");
cover property (cmd_launch);
cover property (protect_hit ##1 !seq_start_ok);
cover property (st_rd && prdata[3]);
endmodule
bind fsef_flash_status fsef_checker chk_u (.*);
`default_nettype wire

// ==== fsef_cmd_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module fsef_cmd_model #(parameter int RUN = 4) (
    input wire logic clk, sys_rst, cmd_launch,
    output wire logic ctrl_busy, cmd_finish
);
logic [3:0] cnt_ff;
always_ff @(posedge clk) begin
    if (sys_rst) begin
        cnt_ff <= 4'h0;
    end else if (cmd_launch) begin
        cnt_ff <= RUN[3:0];
    end else if (cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
    end
end
// busy drops as the finish pulse sets done
assign ctrl_busy = cnt_ff != 4'h0;
assign cmd_finish = cnt_ff == 4'h1;
endmodule
`default_nettype wire

// ==== flash_status_error_flags_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fsef_defs.vh"
module flash_status_error_flags_tb;
localparam [11:0] CF = `FSEF_ADDR_CONFIG, EC = `FSEF_ADDR_ERR_CONFIG;
localparam [11:0] ST = `FSEF_ADDR_STATUS, ER = `FSEF_ADDR_ERR_STATUS;
logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [11:0] paddr = 12'h0;
logic [31:0] pwdata = 32'h0, d;
logic [3:0] pstrb = 4'hf;
logic [1:0] rs = 2'h0;
logic [6:0] evt = 7'h0;
logic e = 1'b0;
wire [31:0] prdata;
wire pready, pslverr, cmd_launch, seq_ok, fin, busy, dirq, dfi, sfi;
int mismatches = 0, checks_done = 0, cyc = 0;
always #5 clk = ~clk;
fsef_flash_status dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .cmd_launch(cmd_launch), .seq_start_ok(seq_ok),
    .cmd_finish(fin), .ctrl_busy(busy), .result_status(rs), .seq_error(evt[6]),
    .illegal_cmd(evt[5]), .protect_hit(evt[4]), .array_read(evt[3]), .ecc_single(evt[2]),
    .ecc_double(evt[1]), .read_collision(evt[0]), .done_irq(dirq),
    .double_fault_irq(dfi), .single_fault_irq(sfi));
fsef_cmd_model cm_u (.clk(clk), .sys_rst(sys_rst), .cmd_launch(cmd_launch),
    .ctrl_busy(busy), .cmd_finish(fin));
task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
task chk(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp) begin
        mismatches++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task xfer(input w, input [11:0] a, input [7:0] v);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, v};
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
endtask
task rchk(input [11:0] a, input [7:0] e);
    xfer(1'b0, a, 8'h0);
    chk(d, {24'h0, e});
endtask
task ev(input [6:0] v);
    @(posedge clk) evt <= v;
    @(posedge clk) evt <= 7'h0;
endtask
task t_cmd;
    rchk(ST, 8'h80); rchk(ER, 8'h00); rchk(CF, 8'h00);
    chk(e, 0); xfer(1'b0, 12'h000, 8'h0); chk(d, 0); chk(e, 1);
    xfer(1'b1, CF, 8'h80); rs <= 2'h2;
    xfer(1'b1, ST, 8'h00); rchk(ST, 8'h82);
    xfer(1'b1, ST, 8'h80); rchk(ST, 8'h0a); chk(dirq, 0);
    for (int i = 0; i < 20 && d[7] !== 1'b1; i++) xfer(1'b0, ST, 8'h0);
    chk(d, 32'h82); chk(dirq, 1);
    rs <= 2'h0; xfer(1'b1, ST, 8'h7f); rchk(ST, 8'h80);
    xfer(1'b1, CF, 8'h00);
    $display("command test done");
endtask
task t_err;
    for (int i = 0; i < 2; i++) begin
        ev(i ? 7'h20 : 7'h40); rchk(ST, 8'ha0);
        xfer(1'b1, ST, 8'h80); xfer(1'b1, ST, 8'h00); rchk(ST, 8'ha0);
        xfer(1'b1, ST, 8'h20); rchk(ST, 8'h80);
    end
    ev(7'h10); rchk(ST, 8'h90); chk(seq_ok, 0);
    xfer(1'b1, ST, 8'h80); xfer(1'b1, ST, 8'h00); rchk(ST, 8'hb0);
    xfer(1'b1, ST, 8'h30); rchk(ST, 8'h80); chk(seq_ok, 1);
    $display("error flag test done");
endtask
task t_ecc;
    logic [23:0] tbl [6] = '{24'h000c01, 24'h000a02, 24'h000903, 24'h100c00, 24'h020802,
        24'h000e02};
    xfer(1'b1, EC, 8'h03);
    foreach (tbl[i]) begin
        xfer(1'b1, CF, tbl[i][23:16]); ev(tbl[i][14:8]); rchk(ER, tbl[i][7:0]);
        chk({dfi, sfi}, tbl[i][1:0]);
        xfer(1'b1, ER, 8'h00); rchk(ER, tbl[i][7:0]);
        xfer(1'b1, ER, 8'h03); rchk(ER, 8'h00);
    end
    xfer(1'b1, CF, 8'h00);
    $display("fault flag test done");
endtask
always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
        mismatches++;
        end_of_test();
    end
end
initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_cmd; t_err; t_ecc;
    end_of_test;
end
endmodule
`default_nettype wire
